// ===== spi_ctl_pkg.sv
// Shared constants and carriers for the serial port control block
package spi_ctl_pkg;
  localparam logic [7:0] ADDR_CTL_STATUS = 8'hF8;
  localparam logic [7:0] ADDR_CLK_DIV = 8'hA2;
  localparam logic [7:0] ADDR_DATA = 8'hA3;
  localparam logic [7:0] ADDR_CONFIG = 8'hA1;
  localparam int BIT_DONE = 7;
  localparam int BIT_WRITE_COLLISION_FLAG = 6;
  localparam int BIT_MODE_FAULT_FLAG = 5;
  localparam int BIT_OVRN = 4;
  localparam int BIT_NSSMD_HI = 3;
  localparam int BIT_NSSMD_LO = 2;
  localparam int BIT_TRANSMIT_BUFFER_EMPTY = 1;
  localparam int BIT_EN = 0;
  localparam int BIT_MASTER = 6;
  localparam int BIT_CPOL = 4;
  localparam logic [7:0] CTL_RESET = 8'h06;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [1:0] NSSMD_RESET = 2'h1;
  localparam logic [1:0] NSSMD_3WIRE = 2'h0;
  localparam logic [1:0] NSSMD_4WIRE_IN = 2'h1;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_TRAIL = 2'b11
  } xfer_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic mosi;
    logic mosi_oe_n;
    logic miso;
    logic miso_oe_n;
    logic slave_select_line;
    logic nss_oe_n;
  } pin_out_t;
endpackage : spi_ctl_pkg

// ===== spi_control_and_clock_rate.sv
// Serial port control, status flags, shifter and master clock divider
//
// Summary of operation
// - Transfer-done flag sets after each byte, drives the request, software clears.
// - Data write during a transfer is dropped and sets the collision flag.
// - Master seeing select line driven active by another sets mode fault.
// - Byte completing while receive buffer unread sets the overrun flag.
// - Select mode: 00 three-wire, 01 select input, 1x select driven out.
// - Transmit-empty reads 0 while a byte waits, 1 once moved to shifter.
// - Enable bit 0 disables the whole port, 1 enables it.
// - Master clock is system clock over two times (divider plus one).
// - Master-role bit 0 means slave, 1 means master driving the clock.
// - Polarity bit 0 idles clock low, 1 idles it high.
module spi_control_and_clock_rate
  import spi_ctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic nss_i,
  output pin_out_t pins,
  output logic irq
);
  logic done_flag, write_collision_flag_flag, mode_fault_flag_flag, ovrn_flag, en;
  logic [1:0] nssmd;
  logic [7:0] div, cfg, tx_buf, rx_buf, shift;
  logic tx_full, rx_full, samp, sck_o, mosi_o, miso_o;
  logic drive_sck_n, drive_miso_n, drive_nss_n, nss_o;
  logic [7:0] div_cnt;
  logic [3:0] bitcnt;
  logic [2:0] sck_s;
  logic [1:0] mosi_s, miso_s, nss_s;
  xfer_state_t state, next_state;

  wire master = cfg[BIT_MASTER];
  wire cpol = cfg[BIT_CPOL];
  wire busy = state != ST_IDLE;
  wire wr_ctl = sfr_req.wr && sfr_req.addr == ADDR_CTL_STATUS;
  wire wr_div = sfr_req.wr && sfr_req.addr == ADDR_CLK_DIV;
  wire wr_cfg = sfr_req.wr && sfr_req.addr == ADDR_CONFIG;
  wire wr_data = sfr_req.wr && sfr_req.addr == ADDR_DATA;
  wire rd_data = sfr_req.rd && sfr_req.addr == ADDR_DATA;
  wire next_en = wr_ctl ? sfr_req.wdata[BIT_EN] : en;
  wire next_master = wr_cfg ? sfr_req.wdata[BIT_MASTER] : master;
  wire [1:0] next_nssmd = wr_ctl ?
                          sfr_req.wdata[BIT_NSSMD_HI:BIT_NSSMD_LO] : nssmd;
  wire nss_low = !nss_s[1];
  wire selected = nssmd == NSSMD_3WIRE || nss_low;
  wire slave_on = en && !master;
  // Edge detect reads only settled stages, never the first flop
  wire sck_edge = sck_s[2] != sck_s[1];
  wire lead_edge = sck_edge && sck_s[1] != cpol;
  wire trail_edge = sck_edge && sck_s[1] == cpol;
  wire tick = div_cnt == div;
  wire master_lead = en && master && state == ST_LEAD && tick;
  wire master_trail = en && master && state == ST_TRAIL && tick;
  wire slave_lead = slave_on && selected && state != ST_TRAIL && lead_edge;
  wire slave_trail = slave_on && selected && state == ST_TRAIL && trail_edge;
  wire do_lead = master_lead || slave_lead;
  wire do_trail = master_trail || slave_trail;
  wire done = do_trail && bitcnt == LAST_BIT;
  wire collide = wr_data && busy;
  wire fault = en && master && nssmd == NSSMD_4WIRE_IN && nss_low;
  wire load = en && state == ST_IDLE && tx_full && !fault;
  wire [7:0] shifted = {shift[6:0], samp};
  wire clr_done = wr_ctl && !sfr_req.wdata[BIT_DONE];
  wire clr_write_collision_flag = wr_ctl && !sfr_req.wdata[BIT_WRITE_COLLISION_FLAG];
  wire clr_mode_fault_flag = wr_ctl && !sfr_req.wdata[BIT_MODE_FAULT_FLAG];
  wire clr_ovrn = wr_ctl && !sfr_req.wdata[BIT_OVRN];
  // Set wins over a clear in the same cycle
  wire next_done = done || (done_flag && !clr_done);
  wire next_write_collision_flag = collide || (write_collision_flag_flag && !clr_write_collision_flag);
  wire next_mode_fault_flag = fault || (mode_fault_flag_flag && !clr_mode_fault_flag);
  wire next_ovrn = (done && rx_full) || (ovrn_flag && !clr_ovrn);
  wire [7:0] ctl_value = {done_flag, write_collision_flag_flag, mode_fault_flag_flag, ovrn_flag,
                          nssmd, !tx_full, en};
  wire [7:0] next_rdata = !sfr_req.rd ? sfr_rdata :
                          sfr_req.addr == ADDR_CTL_STATUS ? ctl_value :
                          sfr_req.addr == ADDR_CLK_DIV ? div :
                          sfr_req.addr == ADDR_CONFIG ? cfg :
                          sfr_req.addr == ADDR_DATA ? rx_buf : 8'h00;

  always_comb begin
    next_state = state;
    if (!en || fault || (slave_on && !selected)) begin
      next_state = ST_IDLE;
    end else if (master) begin
      if (load) begin
        next_state = ST_LEAD;
      end else if (master_lead) begin
        next_state = ST_TRAIL;
      end else if (master_trail) begin
        next_state = done ? ST_IDLE : ST_LEAD;
      end
    end else if (slave_lead) begin
      next_state = ST_TRAIL;
    end else if (slave_trail) begin
      next_state = done ? ST_IDLE : ST_LEAD;
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sck_s <= 3'h0;
      mosi_s <= 2'h0;
      miso_s <= 2'h0;
      nss_s <= 2'h3;
    end else begin
      sck_s <= {sck_s[1:0], sck_i};
      mosi_s <= {mosi_s[0], mosi_i};
      miso_s <= {miso_s[0], miso_i};
      nss_s <= {nss_s[0], nss_i};
    end
  end

  // Registers and flags
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {done_flag, write_collision_flag_flag, mode_fault_flag_flag, ovrn_flag} <= 4'h0;
      en <= CTL_RESET[BIT_EN];
      nssmd <= NSSMD_RESET;
      div <= DIV_RESET;
      cfg <= CONFIG_RESET;
      irq <= 1'b0;
      sfr_rdata <= 8'h00;
    end else begin
      done_flag <= next_done;
      write_collision_flag_flag <= next_write_collision_flag;
      mode_fault_flag_flag <= next_mode_fault_flag;
      ovrn_flag <= next_ovrn;
      irq <= next_done;
      sfr_rdata <= next_rdata;
      if (wr_ctl) begin
        en <= sfr_req.wdata[BIT_EN];
        nssmd <= sfr_req.wdata[BIT_NSSMD_HI:BIT_NSSMD_LO];
      end
      if (wr_div) div <= sfr_req.wdata;
      if (wr_cfg) cfg <= sfr_req.wdata;
    end
  end

  // Buffers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_buf <= 8'h00;
      tx_full <= 1'b0;
      rx_buf <= 8'h00;
      rx_full <= 1'b0;
    end else begin
      if (wr_data && !busy) begin
        tx_buf <= sfr_req.wdata;
        tx_full <= 1'b1;
      end else if (load) begin
        tx_full <= 1'b0;
      end
      if (done && !rx_full) rx_buf <= shifted;
      // Unread byte is kept on overrun
      rx_full <= done || (rx_full && !rd_data);
    end
  end

  // Shifter and clock divider
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      shift <= 8'h00;
      samp <= 1'b0;
      bitcnt <= 4'h0;
      div_cnt <= 8'h00;
      sck_o <= 1'b0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
    end else begin
      state <= next_state;
      div_cnt <= (next_state == ST_IDLE || load || tick) ? 8'h00 :
                 div_cnt + 8'h01;
      if (next_state == ST_IDLE) begin
        sck_o <= cpol;
      end else if (master_lead || master_trail) begin
        sck_o <= !sck_o;
      end
      if (load) begin
        shift <= tx_buf;
        mosi_o <= tx_buf[7];
        miso_o <= tx_buf[7];
        bitcnt <= 4'h0;
      end else if (do_lead) begin
        samp <= master ? miso_s[1] : mosi_s[1];
      end else if (do_trail) begin
        shift <= shifted;
        mosi_o <= shift[6];
        miso_o <= shift[6];
        bitcnt <= bitcnt + 4'h1;
      end
      if (next_state == ST_IDLE && !load && state != ST_IDLE) begin
        bitcnt <= 4'h0;
      end
    end
  end

  // Pin enables from flops; master side follows the write in the same edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      drive_sck_n <= 1'b1;
      drive_miso_n <= 1'b1;
      drive_nss_n <= 1'b1;
      nss_o <= NSSMD_RESET[0];
    end else begin
      drive_sck_n <= !(next_en && next_master);
      // Lags the synchronised select by one cycle, still well inside limits
      drive_miso_n <= !(slave_on && selected);
      drive_nss_n <= !(next_en && next_nssmd[1]);
      nss_o <= next_nssmd[0];
    end
  end

  always_comb begin
    pins.sck = sck_o;
    pins.sck_oe_n = drive_sck_n;
    pins.mosi = mosi_o;
    pins.mosi_oe_n = drive_sck_n;
    pins.miso = miso_o;
    pins.miso_oe_n = drive_miso_n;
    pins.slave_select_line = nss_o;
    pins.nss_oe_n = drive_nss_n;
  end

  sequence s_write_idle;
    wr_data && !busy && en && master && !fault;
  endsequence
  sequence s_wait_then_move;
    tx_full ##1 !tx_full;
  endsequence

  AST_DONE_STICKY: assert property (@(posedge clk_sys) disable iff (!arst_n)
    done_flag && !clr_done |=> done_flag && irq)
    else $error("transfer done flag dropped without a clear");
  AST_WRITE_COLLISION_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_data && busy |=> write_collision_flag_flag && $stable(tx_buf))
    else $error("collision not flagged or write not ignored");
  AST_MODE_FAULT_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
    fault |=> mode_fault_flag_flag && state == ST_IDLE)
    else $error("mode fault not flagged");
  AST_OVRN_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
    done && rx_full |=> ovrn_flag && $stable(rx_buf))
    else $error("overrun not flagged");
  AST_NSS_DRIVE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    en && nssmd[1] && !wr_ctl |=> !pins.nss_oe_n && pins.slave_select_line == nssmd[0])
    else $error("select line not driven in single master mode");
  AST_TRANSMIT_BUFFER_EMPTY: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_write_idle |=> s_wait_then_move)
    else $error("transmit empty status sequence wrong");
  AST_DISABLED: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !en |=> state == ST_IDLE && pins.miso_oe_n)
    else $error("port active while disabled");
  AST_DIV_RATE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $changed(sck_o) && $past(busy) && $past(master) && busy
      |-> $past(div_cnt) == $past(div))
    else $error("serial clock toggled off the divider count");
  AST_IDLE_POL: assert property (@(posedge clk_sys) disable iff (!arst_n)
    en && master && !busy && !load ##1 !busy |-> sck_o == $past(cpol))
    else $error("idle clock level wrong");
  AST_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clr_done && !done |=> !done_flag ##1 !irq)
    else $error("clear did not remove flag and request");
endmodule : spi_control_and_clock_rate

// ===== spi_peer.sv
// Behavioural slave peer facing the master port, phase 0, MSB first
module spi_peer (
  input wire logic sck,
  input wire logic sel,
  input wire logic cpol,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  int cnt = 0;
  wire lead = sck ^ cpol;
  // Released line shows the inverse so a stale bit never passes
  assign miso = sel ? sh[7] : ~sh[7];
  always @(posedge sel) begin
    sh = tx_byte;
    cnt = 0;
  end
  always @(posedge lead) begin
    if (sel) rx_byte = {rx_byte[6:0], mosi};
  end
  always @(negedge lead) begin
    if (sel) begin
      cnt = cnt + 1;
      sh = (cnt == 8) ? tx_byte : {sh[6:0], 1'b0};
      if (cnt == 8) cnt = 0;
    end
  end
endmodule : spi_peer

// ===== spi_control_and_clock_rate_test.sv
// Self-checking bench for the serial port control block
module spi_control_and_clock_rate_test import spi_ctl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic nss_in = 1'b1;
  logic cpol = 1'b0;
  logic [7:0] peer_tx = 8'h00;
  logic [7:0] peer_rx;
  logic [7:0] b;
  logic peer_miso;
  logic sck_drv = 1'b0;
  logic mosi_drv = 1'b0;
  logic [7:0] sent;
  logic [7:0] got;
  pin_out_t pins;
  logic irq;
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h5144;

  always #2 clk_sys = ~clk_sys;

  spi_control_and_clock_rate i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sck_i(sck_drv), .mosi_i(mosi_drv),
    .miso_i(peer_miso), .nss_i(nss_in), .pins(pins), .irq(irq));
  spi_peer i_peer (
    .sck(pins.sck), .sel(~pins.slave_select_line & ~pins.nss_oe_n), .cpol(cpol),
    .mosi(pins.mosi), .tx_byte(peer_tx), .miso(peer_miso),
    .rx_byte(peer_rx));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys) sfr_req = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys) sfr_req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(negedge clk_sys) sfr_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys) sfr_req.rd = 1'b0;
    @(negedge clk_sys) chk(what, exp, sfr_rdata);
  endtask : rd

  task automatic wait_done();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 4000) begin
      failures++;
      end_sim();
    end
  endtask : wait_done

  task automatic wait_tgl(output int n);
    logic s;
    s = pins.sck;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (pins.sck === s && n < 600);
    if (n == 600) begin
      failures++;
      end_sim();
    end
  endtask : wait_tgl

  // Flags are cleared first so irq cannot stand from the last byte
  task automatic xfer(input logic [7:0] d, input logic [7:0] p,
                      input logic c, input logic col, input logic [7:0] st);
    logic [7:0] div;
    int n;
    div = 8'h03 + (rnd() & 8'h03);
    wr(ADDR_CTL_STATUS, 8'h0D);
    cpol = c;
    peer_tx = p;
    wr(ADDR_CONFIG, {3'h2, c, 4'h0});
    wr(ADDR_CLK_DIV, div);
    chk("sck idle", {7'h00, c}, {7'h00, pins.sck});
    wr(ADDR_CTL_STATUS, 8'h09);
    wr(ADDR_DATA, d);
    wait_tgl(n);
    wait_tgl(n);
    chk("half period", div + 8'h01, n[7:0]);
    if (col) wr(ADDR_DATA, 8'hFF);
    wait_done();
    chk("peer rx", d, peer_rx);
    rd(ADDR_CTL_STATUS, st, "status");
  endtask : xfer

  initial begin
    repeat (12) @(negedge clk_sys);
    arst_n = 1'b1;
    rd(ADDR_CTL_STATUS, CTL_RESET, "ctl reset");
    // Unmapped read follows a nonzero one so a stale value shows
    rd(8'h00, 8'h00, "unmapped");
    rd(ADDR_CLK_DIV, DIV_RESET, "div reset");
    peer_tx = 8'hC3;
    wr(ADDR_CLK_DIV, 8'h03);
    wr(ADDR_CONFIG, 8'h40);
    wr(ADDR_CTL_STATUS, 8'h08);
    wr(ADDR_DATA, 8'h5A);
    rd(ADDR_CTL_STATUS, 8'h08, "tx waiting");
    chk("off", 8'h03, {6'h00, pins.mosi_oe_n, pins.sck_oe_n});
    wr(ADDR_CTL_STATUS, 8'h09);
    rd(ADDR_CTL_STATUS, 8'h0B, "tx moved");
    wait_done();
    chk("peer rx", 8'h5A, peer_rx);
    rd(ADDR_CTL_STATUS, 8'h8B, "done");
    rd(ADDR_DATA, 8'hC3, "rx byte");
    wr(ADDR_CTL_STATUS, 8'h09);
    @(negedge clk_sys);
    chk("irq cleared", 8'h00, {7'h00, irq});
    $display("parked byte test over");
    for (int i = 0; i < 3; i++) begin
      b = rnd();
      xfer(rnd(), b, i[0], i == 1, i == 1 ? 8'hCB : 8'h8B);
      rd(ADDR_DATA, b, "rx byte");
    end
    b = rnd();
    xfer(8'h11, b, 1'b0, 1'b0, 8'h8B);
    xfer(8'h22, 8'h33, 1'b1, 1'b0, 8'h9B);
    rd(ADDR_DATA, b, "rx kept");
    $display("transfer test over");
    nss_in = 1'b0;
    wr(ADDR_CTL_STATUS, 8'h05);
    repeat (4) @(negedge clk_sys);
    rd(ADDR_CTL_STATUS, 8'h27, "mode fault");
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTL_STATUS, {4'h0, m[1:0], 2'b01});
      chk("nss oe", {7'h00, m < 2}, {7'h00, pins.nss_oe_n});
      if (m >= 2) chk("nss out", {7'h00, m[0]}, {7'h00, pins.slave_select_line});
    end
    wr(ADDR_CONFIG, 8'h00);
    chk("slave sck", 8'h03, {6'h00, pins.mosi_oe_n, pins.sck_oe_n});
    $display("select mode test over");
    // Bench plays the far master; edges spaced past the pin synchronisers
    nss_in = 1'b1;
    b = rnd();
    sent = rnd();
    wr(ADDR_CTL_STATUS, 8'h05);
    wr(ADDR_DATA, b);
    nss_in = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("miso on", 8'h00, {7'h00, pins.miso_oe_n});
    for (int k = 7; k >= 0; k--) begin
      mosi_drv = sent[k];
      repeat (6) @(negedge clk_sys);
      got[k] = pins.miso;
      sck_drv = 1'b1;
      repeat (6) @(negedge clk_sys);
      sck_drv = 1'b0;
    end
    wait_done();
    chk("slave tx", b, got);
    rd(ADDR_DATA, sent, "slave rx");
    rd(ADDR_CTL_STATUS, 8'h87, "slave done");
    nss_in = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("miso off", 8'h01, {7'h00, pins.miso_oe_n});
    $display("slave test over");
    end_sim();
  end
endmodule : spi_control_and_clock_rate_test
